// ---- logic/vdsf_regs.sv ----
`timescale 1ns/1ps
// What this block does
// - line standard bit after 32 equal fields
// - pll unlock flag bit 2 tracks lock
// - luma overflow sticky, cleared by write
// - chroma overflow sticky, cleared by write
// - input format resets to 0x58
// - input select field picks one input
// - format 000 follows detected line standard
// - nonzero format codes force standard
// - decimation register resets to zero
// - bit 7 chooses fields or frames
// - bit 6 picks first dropped parity
// - drop count out of 60 or 50
// - zero count passes every field
// - status bit 5 shows field parity
// - status resets zero, live bits track
// - data on byte lane 0 only
module vdsf_regs
	import vdsf_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire vdsf_bus_req_t i_bus,
	input wire vdsf_video_ev_t i_video,
	output logic [31:0] o_rdata,
	output logic o_rvalid,
	output logic [3:0] o_input_onehot,
	output logic [2:0] o_std,
	output logic o_lines_625,
	output logic o_drop_field
);
	// ==========================================
	// input synchronisers for decoder-side levels
	// levels change on their own timing; nothing but sync2 reads sync1
	vdsf_video_ev_t sync1;
	vdsf_video_ev_t sync2;
	logic fs_prev;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync1 <= '0;
			sync2 <= '0;
			fs_prev <= 1'b0;
		end else begin
			sync1 <= i_video;
			sync2 <= sync1;
			fs_prev <= sync2.field_start;
		end
	end
	logic field_edge;
	assign field_edge = sync2.field_start & ~fs_prev;
	// ==========================================
	// registers
	logic [7:0] input_format_select;
	logic [7:0] temporal_decimation_control;
	logic luma_flag;
	logic chroma_flag;
	logic lines_flag;
	logic pll_flag;
	logic parity_flag;
	logic [5:0] stable_cnt;
	logic [7:0] next_input_format_select;
	logic [7:0] next_temporal_decimation_control;
	logic next_luma_flag;
	logic next_chroma_flag;
	logic next_lines_flag;
	logic [5:0] next_stable_cnt;
	// ==========================================
	// bus decode
	// only lane 0 carries register data; upper lanes are never stored
	logic wr_lane0;
	logic wr_input_format_select;
	logic wr_temporal_decimation_control;
	logic wr_status;
	assign wr_lane0 = i_bus.req & i_bus.wr & i_bus.be[0];
	assign wr_input_format_select = wr_lane0 && i_bus.addr == ADDR_INPUT_FORMAT_SELECT_SEL;
	assign wr_temporal_decimation_control = wr_lane0 && i_bus.addr == ADDR_TEMPORAL_DECIMATION_CONTROL_CTL;
	assign wr_status = wr_lane0 && i_bus.addr == ADDR_STATUS;
	always_comb begin
		next_input_format_select = input_format_select;
		next_temporal_decimation_control = temporal_decimation_control;
		next_luma_flag = luma_flag;
		next_chroma_flag = chroma_flag;
		next_lines_flag = lines_flag;
		next_stable_cnt = stable_cnt;
		if (wr_input_format_select) begin
			next_input_format_select = i_bus.wdata;
			next_input_format_select[IF_RO_HI:IF_RO_LO] = IF_RO_VALUE;
		end
		if (wr_temporal_decimation_control) begin
			next_temporal_decimation_control = i_bus.wdata;
		end
		// writing a one clears; a new overflow in the same cycle wins
		if (wr_status) begin
			if (i_bus.wdata[STAT_LUMA_BIT]) begin
				next_luma_flag = 1'b0;
			end
			if (i_bus.wdata[STAT_CHROMA_BIT]) begin
				next_chroma_flag = 1'b0;
			end
		end
		if (sync2.luma_ovf) begin
			next_luma_flag = 1'b1;
		end
		if (sync2.chroma_ovf) begin
			next_chroma_flag = 1'b1;
		end
		// count fields disagreeing with the reported standard
		if (field_edge) begin
			if (sync2.lines_625 == lines_flag) begin
				next_stable_cnt = 6'h00;
			end else if (stable_cnt == LINES_STABLE_FIELDS - 6'h01) begin
				next_lines_flag = sync2.lines_625;
				next_stable_cnt = 6'h00;
			end else begin
				next_stable_cnt = stable_cnt + 6'h01;
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			input_format_select <= INPUT_FORMAT_SELECT_RESET;
			temporal_decimation_control <= TEMPORAL_DECIMATION_CONTROL_RESET;
			luma_flag <= 1'b0;
			chroma_flag <= 1'b0;
			lines_flag <= 1'b0;
			stable_cnt <= 6'h00;
		end else begin
			input_format_select <= next_input_format_select;
			temporal_decimation_control <= next_temporal_decimation_control;
			luma_flag <= next_luma_flag;
			chroma_flag <= next_chroma_flag;
			lines_flag <= next_lines_flag;
			stable_cnt <= next_stable_cnt;
		end
	end
	assign pll_flag = sync2.pll_unlocked;
	assign parity_flag = sync2.field_even;
	// ==========================================
	// format resolution
	// auto mode moves only after 32 stable fields, so it never flickers
	function automatic logic [2:0] resolve_std(input logic [2:0] fmt, input logic pal);
		if (fmt == VDSF_FMT_AUTO) begin
			resolve_std = pal ? VDSF_FMT_PAL_BDGHI : VDSF_FMT_NTSC_M;
		end else begin
			resolve_std = fmt;
		end
	endfunction
	function automatic logic [3:0] mux_onehot(input logic [1:0] sel);
		unique case (sel)
			2'b00: mux_onehot = 4'h8;
			2'b01: mux_onehot = 4'h4;
			2'b10: mux_onehot = 4'h1;
			2'b11: mux_onehot = 4'h2;
		endcase
	endfunction
	logic [2:0] std_now;
	logic pal_period;
	assign std_now = resolve_std(input_format_select[IF_FMT_HI:0], lines_flag);
	// 50-unit period for anything but the 525-line families
	assign pal_period = !(std_now == VDSF_FMT_NTSC_M || std_now == VDSF_FMT_NTSC_JP || std_now == VDSF_FMT_PAL_M);
	logic drop_w;
	// ==========================================
	// decimation
	// decimator sees the same synchronised edge as the status logic
	vdsf_decimator vdsf_decimator_i (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_field_start(field_edge),
		.i_field_even(sync2.field_even),
		.i_pal(pal_period),
		.i_ctl(temporal_decimation_control),
		.o_drop(drop_w)
	);
	// ==========================================
	// read path, one cycle latency, lane 0 only
	logic [7:0] status_byte;
	always_comb begin
		status_byte = STATUS_RESET;
		status_byte[STAT_PARITY_BIT] = parity_flag;
		status_byte[STAT_LINES_BIT] = lines_flag;
		status_byte[STAT_PLL_BIT] = pll_flag;
		status_byte[STAT_LUMA_BIT] = luma_flag;
		status_byte[STAT_CHROMA_BIT] = chroma_flag;
	end
	// unmapped offsets read zero, so software probes of gaps are harmless
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (i_bus.req && !i_bus.wr && i_bus.be[0]) begin
			unique case (i_bus.addr)
				ADDR_STATUS: next_rdata[7:0] = status_byte;
				ADDR_INPUT_FORMAT_SELECT_SEL: next_rdata[7:0] = input_format_select;
				ADDR_TEMPORAL_DECIMATION_CONTROL_CTL: next_rdata[7:0] = temporal_decimation_control;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end
	// ==========================================
	// output stage
	// every output is a flop; the bus decode never reaches a pin directly
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 32'h0000_0000;
			o_rvalid <= 1'b0;
			o_input_onehot <= 4'h1;
			o_std <= 3'h1;
			o_lines_625 <= 1'b0;
			o_drop_field <= 1'b0;
		end else begin
			o_rdata <= next_rdata;
			o_rvalid <= i_bus.req & ~i_bus.wr;
			o_input_onehot <= mux_onehot(input_format_select[IF_MUX_HI:IF_MUX_LO]);
			o_std <= std_now;
			o_lines_625 <= lines_flag;
			o_drop_field <= drop_w;
		end
	end
endmodule

// ---- logic/vdsf_pkg.sv ----
package vdsf_pkg;
	// ==========================================
	// register map, byte addresses on the memory bus
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_INPUT_FORMAT_SELECT_SEL = 12'h004;
	localparam logic [11:0] ADDR_TEMPORAL_DECIMATION_CONTROL_CTL = 12'h008;
	// ==========================================
	// reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] INPUT_FORMAT_SELECT_RESET = 8'h58;
	localparam logic [7:0] TEMPORAL_DECIMATION_CONTROL_RESET = 8'h00;
	// ==========================================
	// field positions
	localparam int STAT_PARITY_BIT = 5;
	localparam int STAT_LINES_BIT = 4;
	localparam int STAT_PLL_BIT = 2;
	localparam int STAT_LUMA_BIT = 1;
	localparam int STAT_CHROMA_BIT = 0;
	localparam int IF_RSVD_BIT = 7;
	localparam int IF_MUX_HI = 6;
	localparam int IF_MUX_LO = 5;
	localparam int IF_RO_HI = 4;
	localparam int IF_RO_LO = 3;
	localparam int IF_FMT_HI = 2;
	localparam int TD_UNIT_BIT = 7;
	localparam int TD_ALIGN_BIT = 6;
	localparam int TD_CNT_HI = 5;
	localparam logic [1:0] IF_RO_VALUE = 2'h3;
	// ==========================================
	// timing counts
	localparam logic [5:0] LINES_STABLE_FIELDS = 6'h20;
	localparam logic [5:0] PERIOD_NTSC = 6'h3c;
	localparam logic [5:0] PERIOD_PAL = 6'h32;
	// ==========================================
	// enumerations
	typedef enum logic [2:0] {
		VDSF_FMT_AUTO = 3'b000,
		VDSF_FMT_NTSC_M = 3'b001,
		VDSF_FMT_NTSC_JP = 3'b010,
		VDSF_FMT_PAL_BDGHI = 3'b011,
		VDSF_FMT_PAL_M = 3'b100,
		VDSF_FMT_PAL_N = 3'b101,
		VDSF_FMT_SECAM = 3'b110,
		VDSF_FMT_PAL_NC = 3'b111
	} vdsf_format_t;
	typedef struct packed {
		logic req;
		logic wr;
		logic [11:0] addr;
		logic [3:0] be;
		logic [7:0] wdata;
	} vdsf_bus_req_t;
	typedef struct packed {
		logic field_start;
		logic field_even;
		logic lines_625;
		logic pll_unlocked;
		logic luma_ovf;
		logic chroma_ovf;
	} vdsf_video_ev_t;
endpackage

// ---- logic/vdsf_decimator.sv ----
`timescale 1ns/1ps
module vdsf_decimator
	import vdsf_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_field_start,
	input wire logic i_field_even,
	input wire logic i_pal,
	input wire logic [7:0] i_ctl,
	output logic o_drop
);
	// ==========================================
	// bresenham style spread: drop when accumulator wraps
	logic [7:0] ctl_live;
	logic [6:0] acc;
	logic [5:0] pos;
	logic started;
	logic drop;
	logic [7:0] next_ctl_live;
	logic [6:0] next_acc;
	logic [5:0] next_pos;
	logic next_started;
	logic next_drop;
	logic [5:0] period;
	logic [6:0] sum;
	logic unit_step;
	assign period = i_pal ? PERIOD_PAL : PERIOD_NTSC;
	always_comb begin
		next_ctl_live = ctl_live;
		next_acc = acc;
		next_pos = pos;
		next_started = started;
		next_drop = drop;
		sum = acc + {1'b0, ctl_live[TD_CNT_HI:0]};
		// frame mode decides on the aligned field; its partner field keeps that verdict
		unit_step = ctl_live[TD_UNIT_BIT] | (i_field_even == ctl_live[TD_ALIGN_BIT]);
		if (i_field_start) begin
			// new settings take hold at the field edge, sequence restarts
			if (i_ctl != ctl_live) begin
				next_ctl_live = i_ctl;
				next_started = 1'b0;
				next_acc = 7'h00;
				next_pos = 6'h00;
				next_drop = 1'b0;
			end else if (ctl_live[TD_CNT_HI:0] == 6'h00) begin
				next_drop = 1'b0;
			end else if (!started) begin
				// first dropped field matches alignment parity
				if (i_field_even == ctl_live[TD_ALIGN_BIT]) begin
					next_started = 1'b1;
					// the first unit is already one drop, so the spread starts empty
					next_acc = 7'h00;
					next_pos = 6'h01;
					next_drop = 1'b1;
				end else begin
					next_drop = 1'b0;
				end
			end else if (unit_step) begin
				// fields or frames per bit 7
				if (ctl_live[TD_UNIT_BIT] || i_field_even == ctl_live[TD_ALIGN_BIT]) begin
					if (pos == period - 6'h01) begin
						next_pos = 6'h00;
					end else begin
						next_pos = pos + 6'h01;
					end
					if (sum >= {1'b0, period}) begin
						next_acc = sum - {1'b0, period};
						next_drop = 1'b1;
					end else begin
						next_acc = sum;
						next_drop = 1'b0;
					end
				end
			end
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ctl_live <= TEMPORAL_DECIMATION_CONTROL_RESET;
			acc <= 7'h00;
			pos <= 6'h00;
			started <= 1'b0;
			drop <= 1'b0;
		end else begin
			ctl_live <= next_ctl_live;
			acc <= next_acc;
			pos <= next_pos;
			started <= next_started;
			drop <= next_drop;
		end
	end
	assign o_drop = drop;
endmodule

// ---- testbench/vdsf_regs_sva.sv ----
`timescale 1ns/1ps
module vdsf_chk
	import vdsf_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire vdsf_bus_req_t i_bus,
	input wire vdsf_video_ev_t i_video,
	input wire logic [31:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic [3:0] o_input_onehot,
	input wire logic [2:0] o_std,
	input wire logic o_lines_625,
	input wire logic o_drop_field
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	logic rd;
	assign rd = i_bus.req && !i_bus.wr;
	// ====
	// bus answers
	rd_answer_a: assert property (rd |=> o_rvalid)
		else $error("read unanswered");
	rv_cause_a: assert property (o_rvalid |-> $past(rd))
		else $error("stray rvalid");
	lane_zero_a: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
		else $error("upper lane set");
	ro_bits_a: assert property (rd && i_bus.be[0] && i_bus.addr == ADDR_INPUT_FORMAT_SELECT_SEL |=> o_rdata[4:3] == 2'h3)
		else $error("format fixed bits");
	rsvd_stat_a: assert property (rd && i_bus.addr == ADDR_STATUS |=> !o_rdata[3])
		else $error("status bit 3 set");
	unmapped_a: assert property (rd && i_bus.addr == 12'h00c |=> o_rdata == 32'h0)
		else $error("unmapped read");
	// ====
	// outputs
	onehot_a: assert property ($onehot(o_input_onehot))
		else $error("input select");
	reset_out_a: assert property ($fell(i_rst) |-> o_input_onehot == 4'h1 && !o_drop_field)
		else $error("reset outputs");
	cover property (rd && i_bus.addr == ADDR_STATUS);
	cover property ($rose(o_drop_field));
	cover property ($rose(o_lines_625));
endmodule

// ---- testbench/vdsf_regs_tb.sv ----
`timescale 1ns/1ps
module vdsf_regs_tb;
	import vdsf_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	vdsf_bus_req_t bus = '0;
	vdsf_video_ev_t vid = '0;
	logic [31:0] rdata;
	logic rvalid;
	logic [3:0] onehot;
	logic [2:0] std;
	logic l625;
	logic drop;
	logic [31:0] v;
	int err_count = 0;
	int compares = 0;
	vdsf_regs vdsf_regs_i (.i_clk, .i_rst, .i_bus(bus), .i_video(vid), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_input_onehot(onehot), .o_std(std), .o_lines_625(l625), .o_drop_field(drop));
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	// ====
	// helpers
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
		@(posedge i_clk);
		bus <= '{1'b1, w, a, be, d};
		@(posedge i_clk);
		bus.req <= 1'b0;
		#1;
		v = rdata;
		chk("rvalid", {31'h0, ~w}, {31'h0, rvalid});
	endtask
	// field start held 3 cycles so the synchroniser cannot miss it
	task automatic fld(input logic ev);
		@(posedge i_clk);
		vid.field_start <= 1'b1;
		vid.field_even <= ev;
		vid.lines_625 <= 1'b1;
		repeat (3) @(posedge i_clk);
		vid.field_start <= 1'b0;
		repeat (5) @(posedge i_clk);
		#1;
	endtask
	// ====
	// scenarios
	task automatic t_reset();
		acc(0, ADDR_STATUS, 0, 4'hf);
		chk("status", 32'h0, v);
		acc(0, ADDR_INPUT_FORMAT_SELECT_SEL, 0, 4'h1);
		chk("input_format_select", 32'h58, v);
		acc(0, ADDR_TEMPORAL_DECIMATION_CONTROL_CTL, 0, 4'h1);
		chk("temporal_decimation_control", 32'h0, v);
		acc(0, 12'h00c, 0, 4'h1);
		chk("unmapped", 32'h0, v);
		chk("std", 32'h1, {29'h0, std});
		chk("onehot", 32'h1, {28'h0, onehot});
	endtask
	task automatic t_flags();
		@(posedge i_clk);
		vid.luma_ovf <= 1'b1;
		vid.chroma_ovf <= 1'b1;
		vid.pll_unlocked <= 1'b1;
		repeat (2) @(posedge i_clk);
		vid.luma_ovf <= 1'b0;
		vid.chroma_ovf <= 1'b0;
		repeat (4) @(posedge i_clk);
		acc(0, ADDR_STATUS, 0, 4'h1);
		chk("status", 32'h7, v);
		acc(1, ADDR_STATUS, 8'h03, 4'h2);
		acc(0, ADDR_STATUS, 0, 4'h1);
		chk("status", 32'h7, v);
		acc(1, ADDR_STATUS, 8'h02, 4'h1);
		acc(0, ADDR_STATUS, 0, 4'h1);
		chk("status", 32'h5, v);
		acc(1, ADDR_STATUS, 8'h09, 4'h1);
		acc(0, ADDR_STATUS, 0, 4'h1);
		chk("status", 32'h4, v);
		@(posedge i_clk);
		vid.pll_unlocked <= 1'b0;
		repeat (4) @(posedge i_clk);
		acc(0, ADDR_STATUS, 0, 4'h1);
		chk("status", 32'h0, v);
	endtask
	task automatic t_mux();
		logic [3:0] oh [4] = '{4'h8, 4'h4, 4'h1, 4'h2};
		for (int i = 0; i < 8; i++) begin
			acc(1, ADDR_INPUT_FORMAT_SELECT_SEL, {1'b0, i[1:0], 2'b00, i[2:0]}, 4'h1);
			acc(0, ADDR_INPUT_FORMAT_SELECT_SEL, 0, 4'h1);
			chk("input_format_select", {25'h0, i[1:0], 2'b11, i[2:0]}, v);
			chk("onehot", {28'h0, oh[i[1:0]]}, {28'h0, onehot});
			chk("std", (i == 0) ? 32'h1 : 32'(i), {29'h0, std});
		end
	endtask
	task automatic t_lines();
		acc(1, ADDR_INPUT_FORMAT_SELECT_SEL, 8'h40, 4'h1);
		for (int i = 0; i < 32; i++) begin
			chk("lines", 32'h0, {31'h0, l625});
			fld(i[0]);
		end
		chk("lines", 32'h1, {31'h0, l625});
		chk("std", 32'h3, {29'h0, std});
		acc(0, ADDR_STATUS, 0, 4'h1);
		chk("parity", 32'h1, {31'h0, v[5]});
	endtask
	// fields start at the aligned parity so each period is whole
	task automatic t_dec(input logic [7:0] c, input int n, input int e);
		int cnt;
		logic first;
		cnt = 0;
		first = 1'b0;
		acc(1, ADDR_TEMPORAL_DECIMATION_CONTROL_CTL, c, 4'h1);
		// settings land on the next field, then one field off the aligned parity
		fld(c[6]);
		chk("restart", 32'h0, {31'h0, drop});
		fld(~c[6]);
		for (int k = 0; k < n; k++) begin
			fld(c[6] ^ k[0]);
			if (drop === 1'b1) begin
				if (cnt == 0) first = vid.field_even;
				cnt++;
			end
		end
		chk("drops", e, cnt);
		if (e > 0) chk("first", {31'h0, c[6]}, {31'h0, first});
	endtask
	task automatic give_verdict();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge i_clk);
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reset();
		t_flags();
		t_mux();
		t_lines();
		t_dec(8'hd9, 50, 25);
		t_dec(8'h99, 50, 25);
		t_dec(8'hb2, 50, 50);
		t_dec(8'h45, 100, 10);
		t_dec(8'h00, 10, 0);
		acc(1, ADDR_INPUT_FORMAT_SELECT_SEL, 8'h41, 4'h1);
		t_dec(8'h9e, 60, 30);
		give_verdict();
	end
endmodule
bind vdsf_regs vdsf_chk vdsf_chk_i (.i_clk, .i_rst, .i_bus, .i_video, .o_rdata, .o_rvalid, .o_input_onehot,
	.o_std, .o_lines_625, .o_drop_field);
